// >>> design/charge_cycle_map.vh
// Register offsets, field positions, reset values and timing counts of the charge controller
`ifndef CHARGE_CYCLE_MAP_VH
`define CHARGE_CYCLE_MAP_VH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_VREG 12'h004
`define OFS_CURRENT 12'h008
`define OFS_ITERM 12'h00c
`define OFS_TIMER 12'h010
`define OFS_COMP 12'h014
`define OFS_MON 12'h018
`define OFS_STATUS 12'h01c
`define OFS_ADC 12'h020
// Control register bits
`define CTRL_CHG_EN 0
`define CTRL_TERM_EN 1
`define CTRL_SW_OFF 2
`define CTRL_IND_OFF 3
`define CTRL_RECHG_SEL 4
`define CTRL_WARM_VSEL 5
`define CTRL_COOL_ISEL 6
`define CTRL_JEITA_EN 7
`define CTRL_BOOST_HOT_LO 8
`define CTRL_BOOST_COLD_THRESHOLD_SELECT 10
// Timer register bits
`define TMR_EN 0
`define TMR_HALF_EN 1
`define TMR_SEL_LO 2
// Monitor register bits
`define MON_TRIG 0
`define MON_CONT 1
// Reset values: 4.208 V, 2.048 A, 128 mA precharge, 256 mA termination (mV / mA)
`define RST_CTRL 12'h083
`define RST_VREG 16'd4208
`define RST_FAST_CHARGE_CURRENT_SETTING 16'd2048
`define RST_IPRE 16'd128
`define RST_ITERM 16'd256
`define RST_TIMER 4'hc
// Battery voltage thresholds in mV, short-battery current in mA
`define VBAT_SHORT 16'd2000
`define VBAT_PRE 16'd3000
`define VBAT_LOWV 16'd3000
`define WARM_DROP 16'd200
`define RECHG_LO 16'd100
`define RECHG_HI 16'd200
`define I_SHORT 16'd100
// Charge phase codes and timer fault code
`define PH_DIS 2'b00
`define PH_PRE 2'b01
`define PH_FAST 2'b10
`define PH_DONE 2'b11
`define FAULT_TIMER 2'b11
// Timing
`define CLK_HZ 50000000
`define ALERT_US 256
`define ALERT_CYC (`ALERT_US * (`CLK_HZ / 1000000))
`define SEC_CYC `CLK_HZ
`define BLINK_CYC (`CLK_HZ / 2)
`define CONV_S 1
`define LOW_BAT_H 4
`endif

// >>> design/charge_cycle_controller.v
// Charge cycle controller: qualification, phase, termination, safety timer, status and monitor
//
// The register offsets and register access over APB are this design's own decisions.
`include "charge_cycle_map.vh"

// Operation
// - Enabled bit and low pin run autonomous cycle
// - Start needs converter, enable, current, no faults
// - Reset defaults for voltage, currents, profile, timer
// - Terminate on low current, high voltage, no regulation
// - Full battery below recharge threshold restarts charging
// - Toggling pin or enable bit restarts after done
// - Indicator low charging, high done, blinks fault
// - Phase field 00 disabled 01 pre 10 fast 11
// - Completion sets done and pulses host alert
// - Each host alert is one 256 us pulse
// - Current picked from battery voltage bands
// - Regulation blocks termination, halves timer rate
// - After termination switch off, supplement still allowed
// - Termination enable cleared prevents termination
// - Regulation voltage plus min of compensation, clamp
// - Charge only inside thermistor window, pause outside
// - Warm drops 200 mV; cool cuts current
// - Boost suspended outside cold/hot window unless 11
// - Timer four hours below low battery, else select
// - Timer expiry sets fault 11 and alerts
// - Half-rate disable counts full rate always
// - One-shot trigger stays set until conversion completes
// - Continuous mode converts each second while selected
module charge_cycle_controller #(
	parameter SEC_CYCLES = `SEC_CYC,
	parameter BLINK_CYCLES = `BLINK_CYC
) (
	input wire SYS_CLK,
	input wire NRST,
	input wire [31:0] PADDR,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	input wire CHARGE_ENABLE_N,
	input wire CONVERTER_STARTED,
	input wire [15:0] VBAT_MV,
	input wire [15:0] IBAT_MA,
	input wire INPUT_CURRENT_LIMIT,
	input wire INPUT_VOLTAGE_LIMIT,
	input wire THERMAL_REG,
	input wire THERM_COLD,
	input wire THERM_COOL,
	input wire THERM_WARM,
	input wire THERM_HOT,
	input wire BOOST_COLD,
	input wire BOOST_HOT,
	input wire BOOST_REQUEST,
	input wire CONV_DONE,
	input wire [15:0] CONV_RESULT,
	output reg CHARGING,
	output reg BATTERY_SWITCH_ON,
	output reg BOOST_RUN,
	output reg [15:0] FAST_CHARGE_CURRENT_SETTING_TARGET_MA,
	output reg [15:0] VREG_TARGET_MV,
	output reg MONITOR_CONVERSION_TRIGGER,
	output reg ALERT,
	output reg STAT_OUT,
	output reg STAT_OE
);
	localparam ST_IDLE = 2'd0;
	localparam ST_CHG = 2'd1;
	localparam ST_DONE = 2'd2;
	localparam ST_FAULT = 2'd3;
	// Alert load kept 32 bits wide so the cut to the counter width is explicit
	localparam [31:0] ALERT_LOAD = `ALERT_CYC;

	reg [11:0] ctrl_q; // Control bits
	reg [15:0] vreg_q; // Programmed regulation voltage, mV
	reg [15:0] fast_charge_current_setting_q; // Fast charge current, mA
	reg [15:0] ipre_q; // Precharge current, mA
	reg [15:0] iterm_q; // Termination current, mA
	reg [5:0] timer_q; // Timer enable, half rate, duration hours
	reg [7:0] comp_r_q; // Compensation resistance, mOhm
	reg [7:0] comp_clamp_q; // Compensation voltage clamp, mV
	reg trig_q; // Monitor conversion trigger
	reg cont_q; // Monitor continuous select
	reg [15:0] adc_q; // Last conversion result
	reg [1:0] state_q; // Charge cycle state
	reg [1:0] phase_q; // Charge phase field
	reg [1:0] fault_q; // Charge fault field
	reg pin_q; // Previous pin enable level
	reg en_q; // Previous combined enable
	reg [25:0] sec_q; // One second timebase
	reg half_q; // Half-rate tick parity
	reg [15:0] secs_q; // Seconds spent in cycle
	reg [14:0] alert_q; // Alert pulse countdown
	reg [24:0] blink_q; // Indicator blink divider
	reg blink_lvl_q; // Blink phase
	reg [25:0] conv_q; // Continuous conversion interval
	reg conv_busy_q; // Conversion in progress

	wire wr = PSEL & PENABLE & PWRITE;
	wire [11:0] addr = PADDR[11:0];
	wire chg_en = ctrl_q[`CTRL_CHG_EN] & ~CHARGE_ENABLE_N;
	wire therm_ok = ~THERM_COLD & ~THERM_HOT;
	// Any regulation loop active
	wire regulating = INPUT_CURRENT_LIMIT | INPUT_VOLTAGE_LIMIT | THERMAL_REG;
	wire can_start = CONVERTER_STARTED & chg_en & (fast_charge_current_setting_q != 16'h0000) & therm_ok
		& (fault_q == 2'b00) & ~ctrl_q[`CTRL_SW_OFF];
	wire [15:0] rechg_mv = vreg_q - (ctrl_q[`CTRL_RECHG_SEL] ? `RECHG_HI : `RECHG_LO);
	// Termination needs all three conditions and the enable bit
	wire term_hit = (IBAT_MA < iterm_q) & (VBAT_MV > rechg_mv) & ~regulating
		& ctrl_q[`CTRL_TERM_EN];
	// Timebase wraps once per second
	wire sec_tick = (sec_q == SEC_CYCLES - 1);
	// Low battery forces the short fixed window
	wire [15:0] limit_s = (VBAT_MV < `VBAT_LOWV) ? ({12'h000, 4'd`LOW_BAT_H} * 16'd3600)
		: ({12'h000, timer_q[5:2]} * 16'd3600);
	wire timer_step = sec_tick & (~(regulating & timer_q[`TMR_HALF_EN]) | half_q);
	wire timer_exp = timer_q[`TMR_EN] & (secs_q >= limit_s);
	// Enable edge restarts a finished cycle
	wire restart = chg_en & ~en_q;
	// Compensation: current times resistance, clamped
	wire [23:0] comp_prod = IBAT_MA * comp_r_q; // mA*mOhm, product in uV
	wire [15:0] comp_mv = comp_prod[23:10]; // Approximate /1000 by shift
	wire [15:0] comp_eff = (comp_mv < {8'h00, comp_clamp_q}) ? comp_mv : {8'h00, comp_clamp_q};
	reg [31:0] rdata;

	// Zero wait states; no error responses
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign PRDATA = rdata;

	// Register readback; unmapped addresses read zero
	always @* begin
		case (addr)
			`OFS_CTRL: rdata = {20'h00000, ctrl_q};
			`OFS_VREG: rdata = {16'h0000, vreg_q};
			`OFS_CURRENT: rdata = {ipre_q, fast_charge_current_setting_q};
			`OFS_ITERM: rdata = {16'h0000, iterm_q};
			`OFS_TIMER: rdata = {26'h0000000, timer_q};
			`OFS_COMP: rdata = {16'h0000, comp_clamp_q, comp_r_q};
			`OFS_MON: rdata = {30'h00000000, cont_q, trig_q};
			`OFS_STATUS: rdata = {26'h0000000, state_q, fault_q, phase_q};
			`OFS_ADC: rdata = {16'h0000, adc_q};
			default: rdata = 32'h00000000;
		endcase
	end

	// Configuration registers written at the APB access edge
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			ctrl_q <= `RST_CTRL;
			vreg_q <= `RST_VREG;
			fast_charge_current_setting_q <= `RST_FAST_CHARGE_CURRENT_SETTING;
			ipre_q <= `RST_IPRE;
			iterm_q <= `RST_ITERM;
			timer_q <= {`RST_TIMER, 2'b11}; // 12 hours, timer and half rate on
			comp_r_q <= 8'h00;
			comp_clamp_q <= 8'h00;
		end else if (wr) begin
			case (addr)
				`OFS_CTRL: ctrl_q <= PWDATA[11:0];
				`OFS_VREG: vreg_q <= PWDATA[15:0];
				`OFS_CURRENT: begin
					fast_charge_current_setting_q <= PWDATA[15:0];
					ipre_q <= PWDATA[31:16];
				end
				`OFS_ITERM: iterm_q <= PWDATA[15:0];
				`OFS_TIMER: timer_q <= PWDATA[5:0];
				`OFS_COMP: begin
					comp_r_q <= PWDATA[7:0];
					comp_clamp_q <= PWDATA[15:8];
				end
				default: ;
			endcase
		end
	end

	// Charge cycle state machine with safety timer
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			state_q <= ST_IDLE;
			phase_q <= `PH_DIS;
			fault_q <= 2'b00;
			secs_q <= 16'h0000;
			sec_q <= 26'h0000000;
			half_q <= 1'b0;
			en_q <= 1'b0;
			pin_q <= 1'b1;
		end else begin
			en_q <= chg_en;
			pin_q <= CHARGE_ENABLE_N;
			sec_q <= sec_tick ? 26'h0000000 : sec_q + 26'h0000001;
			if (sec_tick && regulating)
				half_q <= ~half_q;
			// Reading status clears the fault field, but only outside ST_FAULT
			if (PSEL && PENABLE && !PWRITE && addr == `OFS_STATUS && state_q != ST_FAULT)
				fault_q <= 2'b00;
			case (state_q)
				ST_IDLE: begin
					phase_q <= `PH_DIS;
					secs_q <= 16'h0000;
					if (can_start) begin
						state_q <= ST_CHG;
						phase_q <= (VBAT_MV > `VBAT_PRE) ? `PH_FAST : `PH_PRE;
					end
				end
				ST_CHG: begin
					if (!chg_en) begin
						state_q <= ST_IDLE;
					end else if (timer_exp) begin
						state_q <= ST_FAULT;
						fault_q <= `FAULT_TIMER;
					end else if (term_hit) begin
						state_q <= ST_DONE;
						phase_q <= `PH_DONE;
					end else begin
						if (therm_ok && timer_step)
							secs_q <= secs_q + 16'h0001;
						if (VBAT_MV > `VBAT_PRE)
							phase_q <= `PH_FAST;
					end
				end
				ST_DONE: begin
					secs_q <= 16'h0000;
					// A restart must requalify like any new cycle
					if ((restart || (chg_en && VBAT_MV < rechg_mv)) && can_start) begin
						state_q <= ST_CHG;
						phase_q <= (VBAT_MV > `VBAT_PRE) ? `PH_FAST : `PH_PRE;
					end else if (!chg_en) begin
						state_q <= ST_IDLE;
					end
				end
				ST_FAULT: begin
					phase_q <= `PH_DIS;
					if (!chg_en) begin
						state_q <= ST_IDLE;
						fault_q <= 2'b00;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Targets for the analog loops
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			CHARGING <= 1'b0;
			BATTERY_SWITCH_ON <= 1'b1;
			FAST_CHARGE_CURRENT_SETTING_TARGET_MA <= 16'h0000;
			VREG_TARGET_MV <= `RST_VREG;
			BOOST_RUN <= 1'b0;
		end else begin
			CHARGING <= (state_q == ST_CHG) & therm_ok;
			// Switch off after done; supplement can still turn it on
			BATTERY_SWITCH_ON <= (state_q == ST_CHG) | ~CONVERTER_STARTED
				| (VBAT_MV > VREG_TARGET_MV);
			if (VBAT_MV < `VBAT_SHORT)
				FAST_CHARGE_CURRENT_SETTING_TARGET_MA <= `I_SHORT;
			else if (VBAT_MV <= `VBAT_PRE)
				FAST_CHARGE_CURRENT_SETTING_TARGET_MA <= ipre_q;
			else if (ctrl_q[`CTRL_JEITA_EN] && THERM_COOL)
				FAST_CHARGE_CURRENT_SETTING_TARGET_MA <= ctrl_q[`CTRL_COOL_ISEL] ? {1'b0, fast_charge_current_setting_q[15:1]}
					: fast_charge_current_setting_q / 16'd5;
			else
				FAST_CHARGE_CURRENT_SETTING_TARGET_MA <= fast_charge_current_setting_q;
			VREG_TARGET_MV <= vreg_q + comp_eff
				- ((ctrl_q[`CTRL_JEITA_EN] && THERM_WARM && !ctrl_q[`CTRL_WARM_VSEL])
				? `WARM_DROP : 16'h0000);
			// Boost check off when the hot select is 11
			BOOST_RUN <= BOOST_REQUEST & ((ctrl_q[`CTRL_BOOST_HOT_LO+1:`CTRL_BOOST_HOT_LO] == 2'b11)
				| (~BOOST_COLD & ~BOOST_HOT));
		end
	end

	// Alert pulse and charge indicator
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			alert_q <= 15'h0000;
			ALERT <= 1'b0;
			blink_q <= 25'h0000000;
			blink_lvl_q <= 1'b0;
			STAT_OUT <= 1'b0;
			STAT_OE <= 1'b0;
		end else begin
			// A new event restarts the pulse rather than stretching two
			if ((state_q == ST_CHG) && (term_hit || timer_exp) && chg_en)
				alert_q <= ALERT_LOAD[14:0];
			else if (alert_q != 15'h0000)
				alert_q <= alert_q - 15'h0001;
			ALERT <= (alert_q != 15'h0000);
			blink_q <= (blink_q == BLINK_CYCLES - 1) ? 25'h0000000 : blink_q + 25'h0000001;
			if (blink_q == BLINK_CYCLES - 1)
				blink_lvl_q <= ~blink_lvl_q;
			STAT_OUT <= 1'b0;
			// Open drain: enable pulls low, released reads high
			// Disable bit releases the pin entirely
			if (ctrl_q[`CTRL_IND_OFF])
				STAT_OE <= 1'b0;
			else if (state_q == ST_FAULT || (state_q == ST_CHG && !therm_ok))
				STAT_OE <= blink_lvl_q;
			else
				STAT_OE <= (state_q == ST_CHG);
		end
	end

	// Battery monitor sequencing
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			trig_q <= 1'b0;
			cont_q <= 1'b0;
			adc_q <= 16'h0000;
			conv_q <= 26'h0000000;
			conv_busy_q <= 1'b0;
			MONITOR_CONVERSION_TRIGGER <= 1'b0;
		end else begin
			MONITOR_CONVERSION_TRIGGER <= 1'b0;
			conv_q <= (conv_q == SEC_CYCLES - 1) ? 26'h0000000 : conv_q + 26'h0000001;
			if (CONV_DONE && conv_busy_q) begin
				adc_q <= CONV_RESULT;
				conv_busy_q <= 1'b0;
				if (!cont_q)
					trig_q <= 1'b0;
			end
			if (wr && addr == `OFS_MON) begin
				cont_q <= PWDATA[`MON_CONT];
				if (PWDATA[`MON_TRIG] || PWDATA[`MON_CONT]) begin
					trig_q <= 1'b1;
					conv_busy_q <= 1'b1;
					MONITOR_CONVERSION_TRIGGER <= 1'b1;
					conv_q <= 26'h0000000;
				end else if (!PWDATA[`MON_CONT] && !conv_busy_q) begin
					trig_q <= 1'b0;
				end
			end else if (cont_q && conv_q == SEC_CYCLES - 1) begin
				trig_q <= 1'b1;
				conv_busy_q <= 1'b1;
				MONITOR_CONVERSION_TRIGGER <= 1'b1;
			end
		end
	end
endmodule

// >>> test/adc_model.sv
// Converter-side stand-in that answers the latest conversion start after a fixed delay
module adc_model #(
	parameter int LAT = 5
) (
	input wire SYS_CLK,
	input wire MONITOR_CONVERSION_TRIGGER,
	output logic CONV_DONE,
	output logic [15:0] CONV_RESULT
);
	timeunit 1ns;
	timeprecision 1ns;
	int left_q = 0; // Cycles left in the running conversion
	initial CONV_DONE = 1'b0;
	initial CONV_RESULT = 16'h0000;
	// A new start restarts the count; result is only meaningful with done
	always @(posedge SYS_CLK) begin
		CONV_DONE <= (left_q == 1);
		CONV_RESULT <= (left_q == 1) ? 16'h0e74 : ~CONV_RESULT;
		if (MONITOR_CONVERSION_TRIGGER) begin
			left_q <= LAT;
		end else if (left_q != 0) begin
			left_q <= left_q - 1;
		end
	end
endmodule

// >>> test/charge_cycle_props.sv
// Port-level assertions for the charge cycle controller
`include "charge_cycle_map.vh"
module charge_cycle_props (
	input wire SYS_CLK,
	input wire NRST,
	input wire CHARGE_ENABLE_N,
	input wire CONVERTER_STARTED,
	input wire THERM_COLD,
	input wire THERM_HOT,
	input wire [15:0] VBAT_MV,
	input wire [15:0] FAST_CHARGE_CURRENT_SETTING_TARGET_MA,
	input wire CHARGING,
	input wire ALERT,
	input wire MONITOR_CONVERSION_TRIGGER
);
	localparam int ALERT_N = `ALERT_CYC; // Alert length in cycles
	int alert_len_q; // Cycles the alert has stood high
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);
	// Count alert high time; cleared whenever the alert is low
	always @(posedge SYS_CLK) begin
		if (!NRST || !ALERT) begin
			alert_len_q <= 0;
		end else begin
			alert_len_q <= alert_len_q + 1;
		end
	end
	// CHARGING has just risen: a cycle began or a thermistor pause ended
	sequence s_start;
		$rose(CHARGING);
	endsequence
	a_alert_width: assert property ($fell(ALERT) |-> alert_len_q == ALERT_N)
		else $error("alert pulse length wrong");
	a_alert_cause: assert property ($rose(ALERT) |-> !CHARGING)
		else $error("alert while charging");
	a_start_enable: assert property (s_start |-> $past(CHARGE_ENABLE_N, 2) == 1'b0)
		else $error("charge began with pin high");
	a_start_conv: assert property (s_start |-> $past(CONVERTER_STARTED, 2))
		else $error("charge began without converter");
	a_start_therm: assert property (s_start |-> !$past(THERM_HOT) && !$past(THERM_COLD))
		else $error("charge began outside window");
	a_pause_hot: assert property (THERM_HOT [*3] |-> !CHARGING)
		else $error("charge not paused when hot");
	a_conv_pulse: assert property (MONITOR_CONVERSION_TRIGGER |=> !MONITOR_CONVERSION_TRIGGER)
		else $error("start pulse too long");
	a_short_current: assert property (s_start ##0 (VBAT_MV < `VBAT_SHORT)
		|-> ##[0:2] FAST_CHARGE_CURRENT_SETTING_TARGET_MA == `I_SHORT)
		else $error("short battery current wrong");
endmodule
bind charge_cycle_controller charge_cycle_props props (.*);

// >>> test/charge_cycle_controller_tb.sv
// Self-checking bench for the charge cycle controller
`include "charge_cycle_map.vh"
module charge_cycle_controller_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [31:0] PADDR = 0, PWDATA = 0;
	logic [3:0] PSTRB = 4'hf;
	logic CHARGE_ENABLE_N = 0, CONVERTER_STARTED = 1, INPUT_CURRENT_LIMIT = 0;
	logic INPUT_VOLTAGE_LIMIT = 0, THERMAL_REG = 0, THERM_COLD = 0, THERM_COOL = 0;
	logic THERM_WARM = 0, THERM_HOT = 0, BOOST_COLD = 0, BOOST_HOT = 0, BOOST_REQUEST = 0;
	logic [15:0] VBAT_MV = 16'd3700, IBAT_MA = 16'd1000;
	wire [31:0] PRDATA;
	wire [15:0] CONV_RESULT, FAST_CHARGE_CURRENT_SETTING_TARGET_MA, VREG_TARGET_MV;
	wire PREADY, PSLVERR, CONV_DONE, CHARGING, BATTERY_SWITCH_ON, BOOST_RUN;
	wire MONITOR_CONVERSION_TRIGGER, ALERT, STAT_OUT, STAT_OE;
	int mismatches = 0, compares = 0;
	logic [31:0] rdat; // Data taken at the last access edge
	// Short second keeps timer expiry within 14400 cycles
	charge_cycle_controller #(.SEC_CYCLES(2), .BLINK_CYCLES(8)) dut (.*);
	adc_model adc (.*);
	always #10 SYS_CLK = ~SYS_CLK;
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		rdat = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rc(input logic [31:0] a, m, e);
		apb(1'b0, a, 32'h0);
		chk(rdat & m, e);
	endtask
	// Bounded wait for the charging level
	task automatic till(input logic v);
		for (int i = 0; i < 40 && CHARGING !== v; i++) cyc(1);
		chk(CHARGING, v);
	endtask
	task automatic t_reset;
		rc(`OFS_CTRL, 32'hfff, 32'h083);
		rc(`OFS_VREG, 32'hffff, 32'd4208);
		rc(`OFS_CURRENT, 32'hffffffff, {16'd128, 16'd2048});
		rc(`OFS_ITERM, 32'hffff, 32'd256);
		rc(`OFS_TIMER, 32'h3f, 32'h33);
		apb(1'b1, 32'h40, 32'h5a5a5a5a);
		rc(32'h40, 32'hffffffff, 32'h0);
	endtask
	task automatic t_mon;
		int n;
		apb(1'b1, `OFS_MON, 32'h1);
		rc(`OFS_MON, 32'h1, 32'h1);
		cyc(12);
		rc(`OFS_MON, 32'h1, 32'h0);
		rc(`OFS_ADC, 32'hffff, 32'h0e74);
		apb(1'b1, `OFS_MON, 32'h2);
		cyc(4);
		n = 0;
		for (int i = 0; i < 20; i++) begin
			cyc(1);
			n += MONITOR_CONVERSION_TRIGGER;
		end
		chk(n inside {[9:11]}, 1);
		rc(`OFS_MON, 32'h1, 32'h1);
		apb(1'b1, `OFS_MON, 32'h0);
		cyc(12);
		rc(`OFS_MON, 32'h1, 32'h0);
	endtask
	task automatic t_start;
		till(1);
		rc(`OFS_STATUS, 32'h3, 32'h2);
		chk(FAST_CHARGE_CURRENT_SETTING_TARGET_MA, 16'd2048);
		chk(STAT_OE, 1);
		chk(STAT_OUT, 0);
		THERM_HOT <= 1'b1;
		cyc(5);
		chk(CHARGING, 0);
		THERM_HOT <= 1'b0;
		till(1);
		// Each pass blocks the start by one missing condition
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, `OFS_CTRL, 32'h082);
			till(0);
			rc(`OFS_STATUS, 32'h3, 32'h0);
			chk(STAT_OE, 0);
			CONVERTER_STARTED <= (k != 0);
			THERM_HOT <= (k == 1);
			CHARGE_ENABLE_N <= (k == 2);
			apb(1'b1, `OFS_CURRENT, {16'd128, (k == 3) ? 16'd0 : 16'd2048});
			apb(1'b1, `OFS_CTRL, (k == 4) ? 32'h087 : 32'h083);
			cyc(10);
			chk(CHARGING, 0);
		end
		CONVERTER_STARTED <= 1'b1;
		THERM_HOT <= 1'b0;
		CHARGE_ENABLE_N <= 1'b0;
		apb(1'b1, `OFS_CTRL, 32'h083);
		till(1);
	endtask
	task automatic t_term;
		THERMAL_REG <= 1'b1;
		IBAT_MA <= 16'd100;
		VBAT_MV <= 16'd4200;
		cyc(20);
		chk(CHARGING, 1);
		apb(1'b1, `OFS_CTRL, 32'h081);
		THERMAL_REG <= 1'b0;
		cyc(20);
		chk(CHARGING, 1);
		apb(1'b1, `OFS_CTRL, 32'h083);
		till(0);
		for (int i = 0; i < 5 && ALERT !== 1'b1; i++) cyc(1);
		chk(ALERT, 1);
		rc(`OFS_STATUS, 32'h3, 32'h3);
		chk(BATTERY_SWITCH_ON, 0);
		chk(STAT_OE, 0);
		cyc(12900);
		chk(ALERT, 0);
		VBAT_MV <= 16'd4000;
		till(1);
		VBAT_MV <= 16'd4200;
		till(0);
		IBAT_MA <= 16'd1000;
		CHARGE_ENABLE_N <= 1'b1;
		cyc(3);
		CHARGE_ENABLE_N <= 1'b0;
		till(1);
	endtask
	task automatic t_pre;
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `OFS_CTRL, 32'h082);
			till(0);
			VBAT_MV <= k ? 16'd2500 : 16'd1500;
			apb(1'b1, `OFS_CTRL, 32'h083);
			till(1);
			rc(`OFS_STATUS, 32'h3, 32'h1);
			chk(FAST_CHARGE_CURRENT_SETTING_TARGET_MA, k ? 16'd128 : 16'd100);
		end
	endtask
	// Compensation clamp, warm voltage drop and boost temperature window
	task automatic t_misc;
		apb(1'b1, `OFS_COMP, {16'h0000, 8'd50, 8'd100});
		cyc(2);
		chk(VREG_TARGET_MV, 16'd4258);
		THERM_WARM <= 1'b1;
		cyc(3);
		chk(VREG_TARGET_MV, 16'd4058);
		THERM_WARM <= 1'b0;
		BOOST_REQUEST <= 1'b1;
		BOOST_HOT <= 1'b1;
		cyc(3);
		chk(BOOST_RUN, 0);
		apb(1'b1, `OFS_CTRL, 32'h383);
		cyc(2);
		chk(BOOST_RUN, 1);
		apb(1'b1, `OFS_CTRL, 32'h083);
		BOOST_HOT <= 1'b0;
		cyc(2);
		chk(BOOST_RUN, 1);
		BOOST_REQUEST <= 1'b0;
		apb(1'b1, `OFS_COMP, 32'h0);
	endtask
	// One hour at two cycles a second: 7200 cycles, doubled under regulation when half rate is on (first pass only)
	task automatic t_timer;
		int n;
		logic prv;
		VBAT_MV <= 16'd3700;
		THERMAL_REG <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `OFS_CTRL, 32'h082);
			apb(1'b1, `OFS_TIMER, k ? 32'h5 : 32'h7);
			apb(1'b1, `OFS_CTRL, 32'h083);
			cyc(k ? 6500 : 13000);
			chk(CHARGING, 1);
			cyc(k ? 1500 : 2000);
			chk(CHARGING, 0);
			chk(ALERT, 1);
			n = 0;
			prv = STAT_OE;
			for (int i = 0; i < 40; i++) begin
				cyc(1);
				n += (STAT_OE !== prv);
				prv = STAT_OE;
			end
			chk(n >= 2, 1);
			rc(`OFS_STATUS, 32'hc, 32'hc);
			// Let this alert finish so the next one is a fresh pulse
			if (k == 0)
				cyc(12800);
		end
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		cyc(2);
		NRST <= 1'b1;
		t_reset();
		t_mon();
		t_start();
		t_term();
		t_pre();
		t_misc();
		t_timer();
		tally_and_finish();
	end
	initial begin
		cyc(90000);
		mismatches++;
		tally_and_finish();
	end
endmodule
